// ### core/can_acceptance_filter_match.sv
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "can_accept_defines.svh"

// Operation
// - Every filter keeps an 11-bit standard identifier in bits 15-5 and each compared bit must equal the frame's.
// - Every filter keeps an 18-bit extended identifier, top two bits in bits 1-0 of its standard word, rest in a second word.
// - With the mask type check on, the filter's bit 3 admits only extended frames at 1 and only standard frames at 0.
// - There are sixteen filters, 0 to 15, each with a standard and an extended identifier word.
// - There are three masks, 0 to 2, laid out like the filters.
// - A filter's 2-bit mask source picks mask 0, 1 or 2 for codes 00, 01, 10, and 11 is reserved.
// - The low selection word holds the source fields of filters 7 to 0, two bits each from bit 15 down.
// - The high selection word holds the source fields of filters 15 to 8 in the same way.
// - A mask standard identifier bit at 1 takes part in the compare, at 0 it is ignored.
// - A mask extended identifier bit likewise includes or excludes that bit.
// - A mask type check bit at 1 accepts only frames whose format matches the filter's extended select bit.
// - With the type check off, standard frames compare on the standard identifier, extended on both parts.
// - Bits 4 and 2 of filter and mask standard identifier words are not stored and read as zero.
// - A 16-bit enable word lets filter n accept frames only while bit n is 1.
// - Each filter has a 4-bit destination code, 1111 for the receive FIFO, else that receive buffer number.
module can_acceptance_filter_match
  import can_accept_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_valid,
  input wire logic [10:0] frame_std_id,
  input wire logic [17:0] frame_ext_id,
  input wire logic frame_is_ext,
  output logic result_valid,
  output logic result_accept,
  output logic [3:0] result_filter,
  output logic [3:0] result_dest
);

  localparam int NUM_FILTERS = 16;
  localparam int NUM_MASKS = 3;

  function automatic reg_kind_t decode_kind(input logic [7:0] a);
    logic [7:0] wa;
    wa = {a[7:2], 2'b00};
    if (wa < `MSK_ID_BASE) begin
      decode_kind = wa[2] ? REG_FEID : REG_FSID;
    end else if (wa < (`MSK_ID_BASE + `MSK_ID_SPAN)) begin
      decode_kind = wa[2] ? REG_MEID : REG_MSID;
    end else if (wa == `SEL_LO_ADDR) begin
      decode_kind = REG_SEL_LO;
    end else if (wa == `SEL_HI_ADDR) begin
      decode_kind = REG_SEL_HI;
    end else if (wa == `FEN_ADDR) begin
      decode_kind = REG_FEN;
    end else if (wa >= `DEST_BASE && wa < (`DEST_BASE + `DEST_SPAN)) begin
      decode_kind = REG_DEST;
    end else if (wa == `STAT_ADDR) begin
      decode_kind = REG_STAT;
    end else begin
      decode_kind = REG_NONE;
    end
  endfunction

  function automatic logic [3:0] decode_index(input logic [7:0] a, input reg_kind_t k);
    case (k)
      REG_FSID, REG_FEID: decode_index = a[6:3];
      REG_MSID, REG_MEID: decode_index = {2'b00, a[4:3]};
      REG_DEST: decode_index = {2'b00, a[3:2]};
      default: decode_index = 4'h0;
    endcase
  endfunction

  // Registers are 16 bits wide, so only the two low byte lanes count
  function automatic reg_word_t merge_word(input reg_word_t old_w, input logic [31:0] new_w, input logic [3:0] strb);
    merge_word = old_w;
    if (strb[0]) begin
      merge_word[7:0] = new_w[7:0];
    end
    if (strb[1]) begin
      merge_word[15:8] = new_w[15:8];
    end
  endfunction

  // Bits 4 and 2 are also dropped on the way out, so a high-lane write never exposes them
  function automatic reg_word_t id_clean(input reg_word_t w);
    id_clean = w & `ID_WR_MASK;
  endfunction

  // Reserved source yields an empty mask, so no mask slot outside 0 to 2 is ever read
  function automatic reg_word_t mask_pick(input logic [1:0] s, input reg_word_t m0, input reg_word_t m1,
    input reg_word_t m2);
    case (s)
      2'b00: mask_pick = m0;
      2'b01: mask_pick = m1;
      2'b10: mask_pick = m2;
      default: mask_pick = 16'h0000;
    endcase
  endfunction

  // One compare serves both identifier parts; bits the mask leaves out never count
  function automatic logic bits_agree(input logic [17:0] want, input logic [17:0] got, input logic [17:0] care);
    bits_agree = ((want ^ got) & care) == 18'h0_0000;
  endfunction

  // Identifier storage; no reset, software loads it before the first frame since all filters come up enabled
  reg_word_t fsid_q [NUM_FILTERS];
  reg_word_t feid_q [NUM_FILTERS];
  reg_word_t msid_q [NUM_MASKS];
  reg_word_t meid_q [NUM_MASKS];
  reg_word_t sel_lo_q;
  reg_word_t sel_hi_q;
  reg_word_t fen_q;
  reg_word_t dest_q [4];
  reg_word_t stat_q;

  logic aw_hold_q;
  logic [7:0] awaddr_q;
  logic w_hold_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  // Write path: address and data are caught independently, either order
  wire aw_take = s_axi_awvalid && !aw_hold_q;
  wire w_take = s_axi_wvalid && !w_hold_q;
  wire wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  wire reg_kind_t wr_kind = decode_kind(awaddr_q);
  wire [3:0] wr_idx = decode_index(awaddr_q, wr_kind);
  wire wr_bad = (wr_kind == REG_NONE) || ((wr_kind == REG_MSID || wr_kind == REG_MEID) && wr_idx >= 4'd3);
  wire [15:0] wr_id_word = id_clean(wdata_q[15:0]);

  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (aw_take) begin
      aw_hold_q <= 1'b1;
      awaddr_q <= 8'(s_axi_awaddr);
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (w_take) begin
      w_hold_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end
  end

  // A new address may be caught while this answer waits; it only fires once bready has cleared it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_bad ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Bits 4 and 2 of standard words are never stored, so they read back as zero
  always_ff @(posedge aclk) begin
    if (wr_fire && wr_kind == REG_FSID) begin
      fsid_q[wr_idx] <= merge_word(fsid_q[wr_idx], {16'h0000, wr_id_word}, wstrb_q);
    end
    if (wr_fire && wr_kind == REG_FEID) begin
      feid_q[wr_idx] <= merge_word(feid_q[wr_idx], wdata_q, wstrb_q);
    end
    if (wr_fire && wr_kind == REG_MSID && !wr_bad) begin
      msid_q[wr_idx[1:0]] <= merge_word(msid_q[wr_idx[1:0]], {16'h0000, wr_id_word}, wstrb_q);
    end
    if (wr_fire && wr_kind == REG_MEID && !wr_bad) begin
      meid_q[wr_idx[1:0]] <= merge_word(meid_q[wr_idx[1:0]], wdata_q, wstrb_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_lo_q <= `SEL_RST;
      sel_hi_q <= `SEL_RST;
      // All filters come up enabled, so identifiers must be loaded before the first frame
      fen_q <= `FEN_RST;
      for (int i = 0; i < 4; i++) begin
        dest_q[i] <= `DEST_RST;
      end
    end else if (wr_fire) begin
      if (wr_kind == REG_SEL_LO) begin
        sel_lo_q <= merge_word(sel_lo_q, wdata_q, wstrb_q);
      end
      if (wr_kind == REG_SEL_HI) begin
        sel_hi_q <= merge_word(sel_hi_q, wdata_q, wstrb_q);
      end
      if (wr_kind == REG_FEN) begin
        fen_q <= merge_word(fen_q, wdata_q, wstrb_q);
      end
      if (wr_kind == REG_DEST) begin
        dest_q[wr_idx[1:0]] <= merge_word(dest_q[wr_idx[1:0]], wdata_q, wstrb_q);
      end
    end
  end

  // Read path: one read at a time, answered on the same edge that takes the address
  wire ar_take = s_axi_arvalid && !rvalid_q;
  wire reg_kind_t rd_kind = decode_kind(8'(s_axi_araddr));
  wire [3:0] rd_idx = decode_index(8'(s_axi_araddr), rd_kind);
  wire rd_bad = (rd_kind == REG_NONE) || ((rd_kind == REG_MSID || rd_kind == REG_MEID) && rd_idx >= 4'd3);
  reg_word_t rd_word;

  always_comb begin
    case (rd_kind)
      REG_FSID: rd_word = id_clean(fsid_q[rd_idx]);
      REG_FEID: rd_word = feid_q[rd_idx];
      REG_MSID: rd_word = rd_bad ? 16'h0000 : id_clean(msid_q[rd_idx[1:0]]);
      REG_MEID: rd_word = rd_bad ? 16'h0000 : meid_q[rd_idx[1:0]];
      REG_SEL_LO: rd_word = sel_lo_q;
      REG_SEL_HI: rd_word = sel_hi_q;
      REG_FEN: rd_word = fen_q;
      REG_DEST: rd_word = dest_q[rd_idx[1:0]];
      REG_STAT: rd_word = stat_q;
      default: rd_word = 16'h0000;
    endcase
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= `RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_bad ? `RESP_SLVERR : `RESP_OKAY;
      rdata_q <= {16'h0000, rd_word};
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Matching: all sixteen filters compare in parallel against the frame
  wire [31:0] sel_all = {sel_hi_q, sel_lo_q};
  logic [NUM_FILTERS-1:0] hit;

  always_comb begin
    logic [1:0] src;
    logic [15:0] ms;
    logic [15:0] me;
    logic sid_ok;
    logic eid_ok;
    logic type_ok;
    src = 2'b00;
    ms = 16'h0000;
    me = 16'h0000;
    sid_ok = 1'b0;
    eid_ok = 1'b0;
    type_ok = 1'b0;
    for (int f = 0; f < NUM_FILTERS; f++) begin
      src = sel_all[2*f +: 2];
      ms = mask_pick(src, msid_q[0], msid_q[1], msid_q[2]);
      me = mask_pick(src, meid_q[0], meid_q[1], meid_q[2]);
      sid_ok = bits_agree({7'h00, fsid_q[f][`SID_MSB:`SID_LSB]}, {7'h00, frame_std_id},
        {7'h00, ms[`SID_MSB:`SID_LSB]});
      eid_ok = bits_agree({fsid_q[f][`EIDH_MSB:0], feid_q[f]}, frame_ext_id,
        {ms[`EIDH_MSB:0], me});
      // Type check compares frame format against the filter's select bit
      type_ok = !ms[`TYPE_BIT] || (fsid_q[f][`TYPE_BIT] == frame_is_ext);
      // Standard frames ignore the extended part of the compare
      hit[f] = fen_q[f] && (src != `MSK_SRC_RSVD) && type_ok && sid_ok && (eid_ok || !frame_is_ext);
    end
  end

  // Lowest numbered hit wins when several filters match
  logic [3:0] win_idx;
  always_comb begin
    win_idx = 4'h0;
    for (int f = NUM_FILTERS - 1; f >= 0; f--) begin
      if (hit[f]) begin
        win_idx = 4'(f);
      end
    end
  end

  wire any_hit = |hit;
  wire [3:0] win_dest = dest_q[win_idx[3:2]][4*win_idx[1:0] +: 4];

  // Match sees registers as they stood at the frame edge; a write landing on that edge is missed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_valid <= 1'b0;
      result_accept <= 1'b0;
      result_filter <= 4'h0;
      result_dest <= 4'h0;
      stat_q <= `STAT_RST;
    end else begin
      result_valid <= frame_valid;
      if (frame_valid) begin
        result_accept <= any_hit;
        result_filter <= any_hit ? win_idx : 4'h0;
        result_dest <= any_hit ? win_dest : 4'h0;
        stat_q <= 16'({1'b1, 3'b000, any_hit, win_idx, win_dest});
      end
    end
  end

endmodule

`default_nettype wire

// ### core/can_accept_defines.svh
`ifndef CAN_ACCEPT_DEFINES_SVH
`define CAN_ACCEPT_DEFINES_SVH

// Register byte addresses; filter n standard word at 8n, extended word at 8n+4
`define FLT_ID_BASE 8'h00
`define MSK_ID_BASE 8'h80
`define MSK_ID_SPAN 8'h18
`define SEL_LO_ADDR 8'hA0
`define SEL_HI_ADDR 8'hA4
`define FEN_ADDR 8'hA8
`define DEST_BASE 8'hB0
`define DEST_SPAN 8'h10
`define STAT_ADDR 8'hC0

// Identifier word layout
`define SID_MSB 15
`define SID_LSB 5
`define TYPE_BIT 3
`define EIDH_MSB 1
`define ID_WR_MASK 16'hFFEB

// Mask source codes
`define MSK_SRC_RSVD 2'b11

// Reset values
`define SEL_RST 16'h0000
`define FEN_RST 16'hFFFF
`define DEST_RST 16'h0000
`define STAT_RST 16'h0000

// Status word fields
`define STAT_SEEN_BIT 12
`define STAT_HIT_BIT 8

// Bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### core/can_accept_pkg.sv
package can_accept_pkg;

  typedef enum logic [3:0] {
    REG_NONE   = 4'b0000,
    REG_FSID   = 4'b0001,
    REG_FEID   = 4'b0010,
    REG_MSID   = 4'b0011,
    REG_MEID   = 4'b0100,
    REG_SEL_LO = 4'b0101,
    REG_SEL_HI = 4'b0110,
    REG_FEN    = 4'b0111,
    REG_DEST   = 4'b1000,
    REG_STAT   = 4'b1001
  } reg_kind_t;

  typedef logic [15:0] reg_word_t;

endpackage

// ### testbench/can_accept_chk.sv
`timescale 1ns/10ps
`default_nettype none
module can_accept_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_valid,
  input wire logic result_valid,
  input wire logic result_accept,
  input wire logic [3:0] result_filter,
  input wire logic [3:0] result_dest
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  res_late_a: assert property (frame_valid |=> result_valid)
    else $error("no result after frame");
  res_cause_a: assert property (result_valid |-> $past(frame_valid))
    else $error("result without frame");
  miss_zero_a: assert property (result_valid && !result_accept |-> result_filter == 4'h0 && result_dest == 4'h0)
    else $error("miss with nonzero fields");
  res_hold_a: assert property (!frame_valid |=> $stable(result_accept) && $stable(result_dest))
    else $error("result moved without frame");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while busy");
  w_block_a: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
    else $error("write answer without held request");
  r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  cover property (result_valid && result_accept);
  cover property (result_valid && !result_accept);
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind can_acceptance_filter_match can_accept_chk chk (.*);
`default_nettype wire

// ### testbench/can_node_model.sv
`timescale 1ns/10ps
`default_nettype none
module can_node_model (
  input wire logic aclk,
  output var logic frame_valid,
  output var logic [10:0] frame_std_id,
  output var logic [17:0] frame_ext_id,
  output var logic frame_is_ext
);
  initial begin
    frame_valid = 1'b0;
    frame_std_id = 11'h000;
    frame_ext_id = 18'h0_0000;
    frame_is_ext = 1'b0;
  end
  task automatic send(input logic [10:0] s, input logic [17:0] x, input logic e);
    @(posedge aclk);
    frame_valid <= 1'b1;
    frame_std_id <= s;
    frame_ext_id <= x;
    frame_is_ext <= e;
    @(posedge aclk);
    frame_valid <= 1'b0;
    // Lines flip after a frame so a stale id never passes for a fresh one
    frame_std_id <= ~s;
    frame_ext_id <= ~x;
    frame_is_ext <= ~e;
  endtask
endmodule
`default_nettype wire

// ### testbench/can_acceptance_filter_match_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "can_accept_defines.svh"
module can_acceptance_filter_match_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic frame_valid, frame_is_ext, result_valid, result_accept;
  logic [10:0] frame_std_id;
  logic [17:0] frame_ext_id;
  logic [3:0] result_filter, result_dest;
  int err_total = 0;
  int tests_run = 0;
  // Only filters 0, 1, 8, 9 and the masks are set here; the rest stay disabled and, apart from the filter 15 standard word t_prog writes, unknown
  logic [23:0] prog [19] = '{24'h00_2476, 24'h04_4567, 24'h08_54A8, 24'h0C_0000, 24'h40_0000,
    24'h44_0000, 24'h48_0000, 24'h4C_0000, 24'h80_FFE3, 24'h84_FFFF, 24'h88_FFCB, 24'h8C_FFFF,
    24'h90_0000, 24'h94_0000, 24'hA0_0004, 24'hA4_000B, 24'hA8_0003, 24'hB0_003E, 24'hB8_00F0};
  always #12.5 aclk = ~aclk;
  can_acceptance_filter_match uut (.*);
  can_node_model node (.aclk(aclk), .frame_valid(frame_valid), .frame_std_id(frame_std_id),
    .frame_ext_id(frame_ext_id), .frame_is_ext(frame_is_ext));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    cmp({s_axi_rdata[15:0], 14'h0, s_axi_rresp}, {ed, 14'h0, er});
  endtask
  task automatic fr(input logic [10:0] s, input logic [17:0] x, input logic e, input logic [9:0] ex);
    node.send(s, x, e);
    #1;
    cmp({22'h0, result_valid, result_accept, result_filter, result_dest}, {22'h0, ex});
  endtask
  task automatic t_reset;
    rd(`SEL_LO_ADDR, 16'h0000, `RESP_OKAY);
    rd(`SEL_HI_ADDR, 16'h0000, `RESP_OKAY);
    rd(`FEN_ADDR, 16'hFFFF, `RESP_OKAY);
    $display("t_reset done");
  endtask
  task automatic t_prog;
    foreach (prog[i]) wr(prog[i][23:16], prog[i][15:0], `RESP_OKAY);
    rd(8'h00, 16'h2462, `RESP_OKAY);
    rd(8'h88, 16'hFFCB, `RESP_OKAY);
    wr(8'h78, 16'hFFFF, `RESP_OKAY);
    rd(8'h78, 16'hFFEB, `RESP_OKAY);
    rd(`SEL_LO_ADDR, 16'h0004, `RESP_OKAY);
    rd(`SEL_HI_ADDR, 16'h000B, `RESP_OKAY);
    wr(8'h98, 16'h1234, `RESP_SLVERR);
    rd(8'h98, 16'h0000, `RESP_SLVERR);
    $display("t_prog done");
  endtask
  task automatic t_match;
    fr(11'h123, 18'h0_0000, 1'b0, 10'h30E);
    fr(11'h122, 18'h0_0000, 1'b0, 10'h200);
    fr(11'h123, 18'h2_4567, 1'b1, 10'h30E);
    fr(11'h123, 18'h2_4566, 1'b1, 10'h200);
    $display("t_match done");
  endtask
  task automatic t_mode;
    fr(11'h2A4, 18'h0_0000, 1'b1, 10'h313);
    fr(11'h2A5, 18'h0_0000, 1'b0, 10'h200);
    wr(`FEN_ADDR, 16'h0302, `RESP_OKAY);
    fr(11'h000, 18'h0_0000, 1'b0, 10'h39F);
    fr(11'h123, 18'h0_0000, 1'b0, 10'h39F);
    wr(`STAT_ADDR, 16'h0000, `RESP_OKAY);
    rd(`STAT_ADDR, 16'h119F, `RESP_OKAY);
    $display("t_mode done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_prog();
    t_match();
    t_mode();
    complete_run();
  end
  initial begin
    #(25 * 5000);
    err_total++;
    complete_run();
  end
endmodule
`default_nettype wire
